// ===== src/pit_pkg.sv
// Package for the periodic interrupt timer: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite register bus and one 100 MHz clock.
package pit_pkg;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned MAX_CHANNELS = 4;
	// Global registers.
	localparam logic [7:0] MODULE_CTRL_ADDR = 8'h00;
	localparam logic [7:0] LIFETIME_HI_ADDR = 8'h04;
	localparam logic [7:0] LIFETIME_LO_ADDR = 8'h08;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h0C;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h10;
	// Per-channel block: base plus channel times stride.
	localparam logic [7:0] CHAN_BASE_ADDR = 8'h20;
	localparam logic [7:0] CHAN_STRIDE = 8'h10;
	localparam logic [3:0] PERIOD_OFS = 4'h0;
	localparam logic [3:0] COUNT_OFS = 4'h4;
	localparam logic [3:0] CTRL_OFS = 4'h8;
	localparam logic [3:0] FLAG_OFS = 4'hC;
	// Module control fields.
	localparam int unsigned MOD_ENABLE_BIT = 0;
	localparam int unsigned CLK_UNGATE_BIT = 1;
	localparam int unsigned DEBUG_RUN_BIT = 2;
	// Channel control fields.
	localparam int unsigned RUN_BIT = 0;
	localparam int unsigned IRQ_EN_BIT = 1;
	localparam int unsigned CHAIN_BIT = 2;
	localparam int unsigned FLAG_BIT = 0;
	localparam logic [31:0] PERIOD_RESET = 32'h0000_0000;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [31:0] ONE_WORD = 32'h0000_0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic run;
		logic timeout_irq_enable;
		logic chain;
	} chan_ctrl_s;

	typedef struct packed {
		logic mod_enable;
		logic clk_ungate;
		logic debug_run_select;
	} mod_ctrl_s;
endpackage : pit_pkg

// ===== src/periodic_interrupt_timer.sv
// Periodic interrupt timer: down-counting channels with chaining and an
// AXI4-Lite register slave. Assumes one clock and an active-low reset.
module periodic_interrupt_timer #(
	parameter int unsigned NUM_CHANNELS = 4
) (
	input wire logic I_MCLK,
	input wire logic I_RST_B,
	input wire logic I_DEBUG_HALT,
	input wire logic [7:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [NUM_CHANNELS-1:0] O_TRIGGER,
	output logic [NUM_CHANNELS-1:0] O_CHAN_IRQ,
	output logic O_IRQ
);

	////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic rst_meta_b;
	logic rst_b;

	always_ff @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rst_meta_b <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_b <= rst_meta_b;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus write channel capture.

	logic [7:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic wr_fire;

	assign wr_fire = aw_held && w_held && !O_BVALID;

	always_ff @(posedge I_MCLK or negedge rst_b) begin
		if (!rst_b) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
			O_AWREADY <= 1'b0;
		end else if (O_AWREADY && I_AWVALID) begin
			aw_held <= 1'b1;
			aw_addr <= I_AWADDR;
			O_AWREADY <= 1'b0;
		end else if (wr_fire) begin
			aw_held <= 1'b0;
		end else begin
			O_AWREADY <= !aw_held && !O_BVALID;
		end
	end

	always_ff @(posedge I_MCLK or negedge rst_b) begin
		if (!rst_b) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			O_WREADY <= 1'b0;
		end else if (O_WREADY && I_WVALID) begin
			w_held <= 1'b1;
			w_data <= I_WDATA;
			w_strb <= I_WSTRB;
			O_WREADY <= 1'b0;
		end else if (wr_fire) begin
			w_held <= 1'b0;
		end else begin
			O_WREADY <= !w_held && !O_BVALID;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address decode.

	logic wr_mod;
	logic wr_mask;
	logic wr_status;
	logic wr_chan;
	logic [1:0] wr_idx;
	logic [3:0] wr_ofs;
	logic wr_ok;
	logic wr_full;

	// One past the last channel register block.
	localparam logic [7:0] CHAN_END_ADDR = 8'(pit_pkg::CHAN_BASE_ADDR +
		pit_pkg::CHAN_STRIDE * pit_pkg::MAX_CHANNELS);

	assign wr_full = (w_strb == 4'hF);
	assign wr_idx = 2'((aw_addr - pit_pkg::CHAN_BASE_ADDR) /
		pit_pkg::CHAN_STRIDE);
	assign wr_ofs = aw_addr[3:0];
	assign wr_chan = (aw_addr >= pit_pkg::CHAN_BASE_ADDR) &&
		(32'(wr_idx) < NUM_CHANNELS) && (aw_addr < CHAN_END_ADDR);
	assign wr_mod = aw_addr == pit_pkg::MODULE_CTRL_ADDR;
	assign wr_mask = aw_addr == pit_pkg::IRQ_MASK_ADDR;
	assign wr_status = aw_addr == pit_pkg::IRQ_STATUS_ADDR;
	assign wr_ok = wr_mod || wr_mask || wr_status || wr_chan ||
		aw_addr == pit_pkg::LIFETIME_HI_ADDR ||
		aw_addr == pit_pkg::LIFETIME_LO_ADDR;

	always_ff @(posedge I_MCLK or negedge rst_b) begin
		if (!rst_b) begin
			O_BVALID <= 1'b0;
			O_BRESP <= pit_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			O_BVALID <= 1'b1;
			O_BRESP <= wr_ok ? pit_pkg::RESP_OKAY : pit_pkg::RESP_SLVERR;
		end else if (I_BREADY) begin
			O_BVALID <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Module control.

	pit_pkg::mod_ctrl_s mod_ctrl;
	logic tick_en;

	always_ff @(posedge I_MCLK or negedge rst_b) begin
		if (!rst_b) begin
			mod_ctrl <= '0;
		end else if (wr_fire && wr_mod && wr_full) begin
			mod_ctrl.mod_enable <= w_data[pit_pkg::MOD_ENABLE_BIT];
			mod_ctrl.clk_ungate <= w_data[pit_pkg::CLK_UNGATE_BIT];
			mod_ctrl.debug_run_select <= w_data[pit_pkg::DEBUG_RUN_BIT];
		end
	end

	// Counting needs the module on, its clock ungated, and no frozen debug.
	assign tick_en = mod_ctrl.mod_enable && mod_ctrl.clk_ungate &&
		(mod_ctrl.debug_run_select || !I_DEBUG_HALT);

	////////////////////////////////////////////////////////////////////////
	// Channels.

	logic [31:0] period [NUM_CHANNELS];
	logic [31:0] count [NUM_CHANNELS];
	logic [NUM_CHANNELS-1:0] expire;
	logic [NUM_CHANNELS-1:0] timeout_flag;
	logic [NUM_CHANNELS-1:0] irq_mask;
	pit_pkg::chan_ctrl_s chan_ctrl [NUM_CHANNELS];

	always_ff @(posedge I_MCLK or negedge rst_b) begin
		if (!rst_b) begin
			irq_mask <= '0;
		end else if (wr_fire && wr_mask && wr_full) begin
			irq_mask <= w_data[NUM_CHANNELS-1:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHANNELS; gi++) begin : g_chan
			logic wr_here;
			logic step;
			logic chained;
			logic was_run;
			logic clr_flag;
			logic next_irq_en;

			assign wr_here = wr_fire && wr_chan && wr_full &&
				(32'(wr_idx) == gi);
			assign clr_flag = (wr_fire && wr_chan && (32'(wr_idx) == gi) &&
				wr_ofs == pit_pkg::FLAG_OFS && w_data[pit_pkg::FLAG_BIT]) ||
				(wr_fire && wr_status && w_data[gi]);
			// The request follows the enable it holds after this edge.
			assign next_irq_en = (wr_here && wr_ofs == pit_pkg::CTRL_OFS) ?
				w_data[pit_pkg::IRQ_EN_BIT] :
				chan_ctrl[gi].timeout_irq_enable;
			if (gi == 0) begin : g_first
				assign chained = 1'b0;
				assign step = tick_en;
			end else begin : g_next
				assign chained = chan_ctrl[gi].chain;
				assign step = tick_en && (!chained || expire[gi-1]);
			end
			assign expire[gi] = tick_en && chan_ctrl[gi].run && was_run &&
				step && count[gi] == pit_pkg::ZERO_WORD;

			always_ff @(posedge I_MCLK or negedge rst_b) begin
				if (!rst_b) begin
					chan_ctrl[gi] <= '0;
					period[gi] <= pit_pkg::PERIOD_RESET;
				end else if (wr_here && wr_ofs == pit_pkg::CTRL_OFS) begin
					chan_ctrl[gi].run <= w_data[pit_pkg::RUN_BIT];
					chan_ctrl[gi].timeout_irq_enable <=
						w_data[pit_pkg::IRQ_EN_BIT];
					chan_ctrl[gi].chain <= w_data[pit_pkg::CHAIN_BIT];
				end else if (wr_here && wr_ofs == pit_pkg::PERIOD_OFS) begin
					period[gi] <= w_data;
				end
			end

			always_ff @(posedge I_MCLK or negedge rst_b) begin
				if (!rst_b) begin
					was_run <= 1'b0;
					count[gi] <= pit_pkg::COUNT_RESET;
				end else if (!chan_ctrl[gi].run) begin
					was_run <= 1'b0;
				end else if (!was_run) begin
					was_run <= 1'b1;
					count[gi] <= period[gi];
				end else if (step) begin
					if (count[gi] == pit_pkg::ZERO_WORD) begin
						count[gi] <= period[gi];
					end else begin
						count[gi] <= count[gi] - pit_pkg::ONE_WORD;
					end
				end
			end

			always_ff @(posedge I_MCLK or negedge rst_b) begin
				if (!rst_b) begin
					timeout_flag[gi] <= 1'b0;
					O_TRIGGER[gi] <= 1'b0;
					O_CHAN_IRQ[gi] <= 1'b0;
				end else begin
					O_TRIGGER[gi] <= expire[gi];
					if (expire[gi]) begin
						timeout_flag[gi] <= 1'b1;
					end else if (clr_flag) begin
						timeout_flag[gi] <= 1'b0;
					end
					O_CHAN_IRQ[gi] <= (timeout_flag[gi] || expire[gi]) &&
						!(clr_flag && !expire[gi]) &&
						next_irq_en;
				end
			end

			a_trigger_follows: assert property (@(posedge I_MCLK)
				disable iff (!rst_b) expire[gi] |=> O_TRIGGER[gi] &&
				timeout_flag[gi]) else $error("no trigger after expiry");
			a_trigger_single: assert property (@(posedge I_MCLK)
				disable iff (!rst_b) O_TRIGGER[gi] && period[gi] != 0 |=>
				!O_TRIGGER[gi]) else $error("trigger too long");
			a_flag_sticky: assert property (@(posedge I_MCLK)
				disable iff (!rst_b) timeout_flag[gi] && !clr_flag |=>
				timeout_flag[gi]) else $error("flag dropped");
			a_frozen_hold: assert property (@(posedge I_MCLK)
				disable iff (!rst_b) !tick_en && was_run &&
				chan_ctrl[gi].run |=> $stable(count[gi]))
				else $error("count moved while frozen");
			a_restart_load: assert property (@(posedge I_MCLK)
				disable iff (!rst_b) chan_ctrl[gi].run && !was_run |=>
				count[gi] == $past(period[gi]))
				else $error("no reload on start");
			a_irq_level: assert property (@(posedge I_MCLK)
				disable iff (!rst_b) O_CHAN_IRQ[gi] |->
				timeout_flag[gi] && chan_ctrl[gi].timeout_irq_enable)
				else $error("irq without flag");
			a_expiry_reload: assert property (@(posedge I_MCLK)
				disable iff (!rst_b) expire[gi] |=>
				count[gi] == $past(period[gi]))
				else $error("no reload at expiry");
			a_flag_clear: assert property (@(posedge I_MCLK)
				disable iff (!rst_b) clr_flag && !expire[gi] |=>
				!timeout_flag[gi]) else $error("flag not cleared");
			if (gi > 0) begin : g_chain_chk
				a_chain_hold: assert property (@(posedge I_MCLK)
					disable iff (!rst_b) chained && was_run &&
					chan_ctrl[gi].run && !expire[gi-1] |=> $stable(count[gi]))
					else $error("chained count moved");
			end
		end
	endgenerate

	a_zero_chain_free: assert property (@(posedge I_MCLK)
		disable iff (!rst_b) tick_en && g_chan[0].was_run &&
		chan_ctrl[0].run && count[0] != 0 |=>
		count[0] == $past(count[0]) - 1)
		else $error("channel zero not free running");

	////////////////////////////////////////////////////////////////////////
	// Read channel.

	logic [1:0] rd_idx;
	logic rd_chan;
	logic [31:0] rd_word;
	logic rd_ok;

	assign rd_idx = 2'((I_ARADDR - pit_pkg::CHAN_BASE_ADDR) /
		pit_pkg::CHAN_STRIDE);
	assign rd_chan = (I_ARADDR >= pit_pkg::CHAN_BASE_ADDR) &&
		(32'(rd_idx) < NUM_CHANNELS) && (I_ARADDR < CHAN_END_ADDR);

	always_comb begin
		rd_word = pit_pkg::ZERO_WORD;
		rd_ok = 1'b1;
		if (rd_chan) begin
			case (I_ARADDR[3:0])
				pit_pkg::PERIOD_OFS: rd_word = period[rd_idx];
				pit_pkg::COUNT_OFS: rd_word = count[rd_idx];
				pit_pkg::CTRL_OFS: rd_word = 32'({chan_ctrl[rd_idx].chain,
					chan_ctrl[rd_idx].timeout_irq_enable,
					chan_ctrl[rd_idx].run});
				pit_pkg::FLAG_OFS: rd_word = 32'(timeout_flag[rd_idx]);
				default: rd_ok = 1'b0;
			endcase
		end else begin
			case (I_ARADDR)
				pit_pkg::MODULE_CTRL_ADDR: rd_word = 32'({
					mod_ctrl.debug_run_select, mod_ctrl.clk_ungate,
					mod_ctrl.mod_enable});
				pit_pkg::LIFETIME_HI_ADDR: rd_word = count[1];
				pit_pkg::LIFETIME_LO_ADDR: rd_word = count[0];
				pit_pkg::IRQ_STATUS_ADDR: rd_word = 32'(timeout_flag);
				pit_pkg::IRQ_MASK_ADDR: rd_word = 32'(irq_mask);
				default: rd_ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge I_MCLK or negedge rst_b) begin
		if (!rst_b) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b0;
			O_RDATA <= 32'h0000_0000;
			O_RRESP <= pit_pkg::RESP_OKAY;
		end else if (O_ARREADY && I_ARVALID) begin
			O_ARREADY <= 1'b0;
			O_RVALID <= 1'b1;
			O_RDATA <= rd_word;
			O_RRESP <= rd_ok ? pit_pkg::RESP_OKAY : pit_pkg::RESP_SLVERR;
		end else if (O_RVALID) begin
			O_RVALID <= !I_RREADY;
		end else begin
			O_ARREADY <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Summary interrupt.

	always_ff @(posedge I_MCLK or negedge rst_b) begin
		if (!rst_b) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(O_CHAN_IRQ & irq_mask);
		end
	end

endmodule : periodic_interrupt_timer

// ===== test/tb_top.sv
// Self-checking bench for the periodic interrupt timer.
// Assumes the AXI4-Lite slave and the pit_pkg map; drives all ports itself.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic I_MCLK = 1'b0;
	logic I_RST_B = 1'b0;
	logic I_DEBUG_HALT = 1'b0;
	logic [7:0] I_AWADDR = 8'h00;
	logic I_AWVALID = 1'b0;
	logic [31:0] I_WDATA = 32'h0;
	logic [3:0] I_WSTRB = 4'hF;
	logic I_WVALID = 1'b0;
	logic I_BREADY = 1'b0;
	logic [7:0] I_ARADDR = 8'h00;
	logic I_ARVALID = 1'b0;
	logic I_RREADY = 1'b0;
	logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_IRQ;
	logic [1:0] O_BRESP, O_RRESP;
	logic [31:0] O_RDATA;
	logic [3:0] O_TRIGGER, O_CHAN_IRQ;
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	int trig0 = 0;
	int t1, t2, k, i;
	logic [31:0] d, a, b, c1;
	logic [1:0] r, wresp;
	logic [2:0] mc [5] = '{3'h3, 3'h1, 3'h2, 3'h3, 3'h7};
	logic hl [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic go [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

	periodic_interrupt_timer #(.NUM_CHANNELS(4)) periodic_interrupt_timer_i (
		.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_DEBUG_HALT(I_DEBUG_HALT),
		.I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY),
		.I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID),
		.O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID),
		.I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
		.O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
		.O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_TRIGGER(O_TRIGGER),
		.O_CHAN_IRQ(O_CHAN_IRQ), .O_IRQ(O_IRQ));

	always #5 I_MCLK = ~I_MCLK;

	always @(posedge I_MCLK) begin
		cyc <= cyc + 1;
		if (O_TRIGGER[0] === 1'b1) trig0 <= trig0 + 1;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] ca(input int ch, input logic [3:0] ofs);
		return pit_pkg::CHAN_BASE_ADDR + 8'(pit_pkg::CHAN_STRIDE * ch)
			+ {4'h0, ofs};
	endfunction : ca

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		int n;
		n = 0;
		@(posedge I_MCLK);
		I_AWADDR <= ad;
		I_WDATA <= dt;
		I_AWVALID <= 1'b1;
		I_WVALID <= 1'b1;
		I_BREADY <= 1'b1;
		do begin
			@(posedge I_MCLK);
			n++;
			if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'b0;
			if (I_WVALID && O_WREADY) I_WVALID <= 1'b0;
			wresp = O_BRESP;
		end while (!(O_BVALID === 1'b1) && n < 100);
		I_BREADY <= 1'b0;
		if (n >= 100) failures++;
	endtask : wr

	task automatic rd(input logic [7:0] ad, output logic [31:0] dt,
		output logic [1:0] rs);
		int n;
		n = 0;
		@(posedge I_MCLK);
		I_ARADDR <= ad;
		I_ARVALID <= 1'b1;
		I_RREADY <= 1'b1;
		do begin
			@(posedge I_MCLK);
			n++;
			if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'b0;
			dt = O_RDATA;
			rs = O_RRESP;
		end while (!(O_RVALID === 1'b1) && n < 100);
		I_RREADY <= 1'b0;
		if (n >= 100) failures++;
	endtask : rd

	task automatic wait_trig(output int t);
		int n;
		n = 0;
		do begin
			@(posedge I_MCLK);
			n++;
		end while (!(O_TRIGGER[0] === 1'b1) && n < 2000);
		t = cyc;
		if (n >= 2000) failures++;
	endtask : wait_trig

	task automatic summarize;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	////////////////////////////////////////////////////////////////////////
	initial begin
		#500us;
		failures++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge I_MCLK);
		I_RST_B <= 1'b1;
		repeat (5) @(posedge I_MCLK);
		rd(ca(0, pit_pkg::PERIOD_OFS), d, r);
		check(d, pit_pkg::PERIOD_RESET);
		rd(8'h14, d, r);
		check(32'(r), 32'(pit_pkg::RESP_SLVERR));
		check(d, 32'h0);
		wr(8'h14, 32'h0);
		check(32'(wresp), 32'(pit_pkg::RESP_SLVERR));
		wr(pit_pkg::MODULE_CTRL_ADDR, 32'h3);
		check(32'(wresp), 32'(pit_pkg::RESP_OKAY));
		wr(ca(0, pit_pkg::PERIOD_OFS), 32'h9);
		// Chain bit on channel zero must be ignored.
		wr(ca(0, pit_pkg::CTRL_OFS), 32'h7);
		wait_trig(t1);
		@(posedge I_MCLK);
		check(32'(O_TRIGGER[0]), 32'h0);
		wait_trig(t2);
		check(32'(t2 - t1), 32'd10);
		rd(ca(0, pit_pkg::FLAG_OFS), d, r);
		check(d, 32'h1);
		check(32'(O_CHAN_IRQ[0]), 32'h1);
		wr(pit_pkg::IRQ_MASK_ADDR, 32'h1);
		repeat (3) @(posedge I_MCLK);
		check(32'(O_IRQ), 32'h1);
		wr(pit_pkg::IRQ_MASK_ADDR, 32'h0);
		repeat (3) @(posedge I_MCLK);
		check(32'(O_IRQ), 32'h0);
		rd(ca(0, pit_pkg::COUNT_OFS), d, r);
		check(32'(d <= 32'd9), 32'h1);
		wr(ca(0, pit_pkg::CTRL_OFS), 32'h2);
		rd(ca(0, pit_pkg::COUNT_OFS), a, r);
		repeat (20) @(posedge I_MCLK);
		rd(ca(0, pit_pkg::COUNT_OFS), b, r);
		check(b, a);
		wr(ca(0, pit_pkg::PERIOD_OFS), 32'd1000);
		wr(ca(0, pit_pkg::CTRL_OFS), 32'h3);
		rd(ca(0, pit_pkg::COUNT_OFS), d, r);
		check(32'(d >= 32'd990 && d <= 32'd1000), 32'h1);
		wr(ca(0, pit_pkg::PERIOD_OFS), 32'd9);
		rd(ca(0, pit_pkg::COUNT_OFS), d, r);
		check(32'(d > 32'd9), 32'h1);
		wait_trig(t1);
		rd(ca(0, pit_pkg::COUNT_OFS), d, r);
		check(32'(d <= 32'd9), 32'h1);
		wr(ca(0, pit_pkg::CTRL_OFS), 32'h0);
		repeat (2) @(posedge I_MCLK);
		check(32'(O_CHAN_IRQ[0]), 32'h0);
		wr(ca(0, pit_pkg::FLAG_OFS), 32'h0);
		rd(ca(0, pit_pkg::FLAG_OFS), d, r);
		check(d, 32'h1);
		wr(ca(0, pit_pkg::FLAG_OFS), 32'h1);
		rd(ca(0, pit_pkg::FLAG_OFS), d, r);
		check(d, 32'h0);
		// Channel one counts channel zero expiries only.
		wr(ca(1, pit_pkg::PERIOD_OFS), 32'd100);
		wr(ca(1, pit_pkg::CTRL_OFS), 32'h5);
		wr(ca(0, pit_pkg::PERIOD_OFS), 32'd4);
		k = trig0;
		wr(ca(0, pit_pkg::CTRL_OFS), 32'h1);
		repeat (200) @(posedge I_MCLK);
		wr(pit_pkg::MODULE_CTRL_ADDR, 32'h0);
		repeat (5) @(posedge I_MCLK);
		k = trig0 - k;
		rd(ca(1, pit_pkg::COUNT_OFS), c1, r);
		check(c1, 32'(100 - k));
		rd(ca(0, pit_pkg::COUNT_OFS), a, r);
		rd(pit_pkg::LIFETIME_HI_ADDR, d, r);
		check(d, c1);
		rd(pit_pkg::LIFETIME_LO_ADDR, d, r);
		check(d, a);
		for (i = 0; i < 5; i++) begin
			wr(pit_pkg::MODULE_CTRL_ADDR, 32'(mc[i]));
			I_DEBUG_HALT <= hl[i];
			repeat (3) @(posedge I_MCLK);
			k = trig0;
			repeat (30) @(posedge I_MCLK);
			check(32'(trig0 != k), 32'(go[i]));
		end
		summarize();
	end
endmodule : tb_top
